/* File: verilog/intc_map.vh */
`ifndef INTC_MAP_VH
`define INTC_MAP_VH
// Function
// - watch overflow slot 21, serial2 vector 003a
// - pin2 and timer4 share slot 15
// - serial1 slot 20, vector 002e, word fe2e
// - illegal operand traps to vector 003c
// - break via 003e; context break switches banks
// - vector from table; four priority levels
// - context switch: bank, save pc/psw
// - context switch on interrupt or break
// - macro service moves data, cpu untouched
// - counter mode decrements; zero gives interrupt
// - compound mode: four kinds, three each
// - compound mode may exchange operands
// - compound mode interrupts at zero count
// - single transfer per request; interrupt at zero count
// - single-transfer buffer inside fe00 to feff
// - pattern mode shifts bit 7, compares
// - pattern interrupt on match or zero
// - optional threshold product written back
// - halt stops cpu; macro still runs
// - stop halts every internal operation
// - low power runs subclock; halt variant
// - timer0 match0 slot 4, vector 000e

// ===================================================
// source table
`define NSRC 26
`define SHARED_SLOT 15
`define LAST_SLOT 5'd25
`define VEC_BASE 16'h0006
`define VEC_LAST 16'h003a
`define MSW_BASE 16'hfe06
`define MSW_LAST 16'hfe3a
`define VEC_TRAP 16'h003c
`define VEC_BRK 16'h003e
`define BUF_PAGE 8'hfe
// ===================================================
// register offsets
`define A_MODE 8'h20
`define A_CNT 8'h21
`define A_P1 8'h22
`define A_MPTR 8'h23
`define A_P2 8'h24
`define A_P3 8'h25
`define A_COEF 8'h26
`define A_CMP 8'h27
`define A_PBUF 8'h28
`define A_XCNT 8'h29
`define STANDBY_CONTROL_REG 8'h2a
`define A_STAT 8'h2b
`define A_MSW 8'h2c
// ===================================================
// fields and codes
`define CTRL_RST 8'h07
`define HM_VEC 2'h0
`define HM_CTX 2'h1
`define HM_MAC 2'h2
`define MS_CNT 2'h0
`define MS_CMP 2'h1
`define MS_ONE 2'h2
`define MS_PAT 2'h3
`define SB_RUN 3'h0
`define SB_HALT 3'h1
`define SB_STOP 3'h2
`define SB_LP 3'h3
`define SB_LPH 3'h4
`define K_VEC 2'h0
`define K_CTX 2'h1
`define K_TRAP 2'h2
`define K_BRK 2'h3
`define COEF_FRAC 4
`endif

/* File: verilog/intc_unit.v */
`timescale 1ns/1ps
`include "intc_map.vh"
module intc_unit
(
  input  wire        clk,               // system clock
  input  wire        rst_n,             // sync reset, low
  input  wire [7:0]  addr,              // register index
  input  wire [15:0] wdata,             // write data
  input  wire        wr,                // write strobe
  input  wire        rd,                // read strobe
  output reg  [15:0] rdata,             // read data, next cycle
  input  wire [25:0] src_req,           // request pulses, bit=slot
  input  wire        pin2_edge_req,     // pin 2 edge pulse
  input  wire        timer4_match_req,  // timer 4 match pulse
  input  wire        operand_err,       // illegal operand pulse
  input  wire        software_break_op, // break executed
  input  wire        context_break_op,  // context break executed
  input  wire [2:0]  break_bank,        // bank for context break
  input  wire        cpu_int_ack,       // cpu took the request
  output reg         cpu_int_req,       // request to cpu
  output reg  [15:0] cpu_vector,        // table entry address
  output reg  [1:0]  cpu_kind,          // vec/ctx/trap/break
  output reg  [2:0]  cpu_bank,          // bank for context switch
  output reg  [1:0]  cpu_level,         // level of request
  output reg  [15:0] bus_addr,          // macro bus address
  output reg         bus_sfr,           // 1: sfr space
  output reg  [15:0] bus_wdata,         // macro write data
  output reg         bus_word,          // 1: word access
  output reg         bus_rd,            // macro read strobe
  output reg         bus_wr,            // macro write strobe
  input  wire [15:0] bus_rdata,         // read data, next cycle
  output reg         cpu_clk_en,        // cpu clock runs
  output reg         main_osc_en,       // main oscillator on
  output reg         sub_clk_sel,       // system on subclock
  output reg         periph_clk_en      // peripherals clocked
);

// ===================================================
// states
localparam [11:0] S_IDLE = 12'h001;
localparam [11:0] S_CPU  = 12'h002;
localparam [11:0] S_RD1  = 12'h004;
localparam [11:0] S_RD2  = 12'h008;
localparam [11:0] S_WR1  = 12'h010;
localparam [11:0] S_WR2  = 12'h020;
localparam [11:0] S_NXT  = 12'h040;
localparam [11:0] S_PAT  = 12'h080;
localparam [11:0] S_PCMP = 12'h100;
localparam [11:0] S_PMUL = 12'h200;
localparam [11:0] S_PWR  = 12'h400;
localparam [11:0] S_FIN  = 12'h800;

reg  [11:0] state;       // sequencer state
reg  [4:0]  sel;         // slot in service
reg  [1:0]  kind;        // compound kind in progress
reg  [1:0]  sub;         // transfer within kind
reg  [3:0]  xi;          // transfers done this request
reg  [7:0]  moff;        // memory offset this request
reg  [15:0] data_a;      // first operand read
reg         match;       // pattern matched
reg  [7:0]  cnt;         // service_transfer_counter
reg  [15:0] mem_ptr;     // memory pointer
reg  [15:0] pbuf;        // pattern buffer
reg  [5:0]  ms_mode;     // macro mode bits
reg  [7:0]  p1;          // sfr pointer 1
reg  [7:0]  p2;          // sfr pointer 2
reg  [7:0]  p3;          // sfr pointer 3
reg  [7:0]  coef;        // threshold coefficient
reg  [15:0] cmp;         // compare area
reg  [7:0]  xcnt;        // compound counts, 2 bits per kind
reg  [2:0]  stby;        // standby mode
reg         trap_p;      // trap pending
reg         brk_p;       // break pending
reg         ctx_p;       // context break pending
reg  [2:0]  ctx_bank;    // bank latched with context break
wire [25:0] el_v;        // pending and unmasked
wire [51:0] lvl_v;       // levels
wire [51:0] md_v;        // handling modes
wire [77:0] bank_v;      // banks
wire [233:0] rd_v;       // control words for readback
wire [25:0] req_v;       // request pulses per slot
wire [25:0] clr_v;       // slot taken this cycle

// ===================================================
// helpers
function [15:0] vec_of;
  input [4:0] i;
  begin
    if (i == `LAST_SLOT)
      vec_of = `VEC_LAST;
    else
      vec_of = `VEC_BASE + {10'h000, i, 1'b0};
  end
endfunction

function [15:0] msw_of;
  input [4:0] i;
  begin
    if (i == `LAST_SLOT)
      msw_of = `MSW_LAST;
    else
      msw_of = `MSW_BASE + {10'h000, i, 1'b0};
  end
endfunction

// ===================================================
// per-source control words and flags
genvar g;
generate
  for (g = 0; g < `NSRC; g = g + 1)
  begin : slot
    localparam [7:0] GA = g;
    reg  [7:0] cfg;  // {bank, mode, mask, level}
    reg        flag; // pending
    wire       hit = wr && (addr == GA);
    // slot 15 carries three requests on one vector
    if (g == `SHARED_SLOT)
    begin : sh
      assign req_v[g] = src_req[g] | pin2_edge_req |
                        timer4_match_req;
    end
    else
    begin : ns
      assign req_v[g] = src_req[g];
    end
    // set wins over clear so no edge is lost
    always @(posedge clk)
    begin
      if (!rst_n)
      begin
        cfg  <= `CTRL_RST;
        flag <= 1'b0;
      end
      else
      begin
        if (hit)
          cfg <= {wdata[8:4], wdata[2:0]};
        flag <= req_v[g] | (hit ? wdata[3] : (flag & ~clr_v[g]));
      end
    end
    assign el_v[g]   = flag & ~cfg[2];
    assign lvl_v[2*g +: 2]  = cfg[1:0];
    assign md_v[2*g +: 2]   = cfg[4:3];
    assign bank_v[3*g +: 3] = cfg[7:5];
    assign rd_v[9*g +: 9]   = {cfg[7:3], flag, cfg[2:0]};
  end
endgenerate

// ===================================================
// arbiter: lowest level, ties to lowest slot
reg  [4:0] best;  // winning slot
reg  [2:0] bl;    // winning level
reg        any_el; // some request eligible
integer    i;
always @*
begin
  best   = 5'd0;
  bl     = 3'd4;
  any_el = 1'b0;
  // walk downward so a later equal level overwrites
  for (i = `NSRC - 1; i >= 0; i = i - 1)
  begin
    if (el_v[i] && ({1'b0, lvl_v[2*i +: 2]} <= bl))
    begin
      best   = i[4:0];
      bl     = {1'b0, lvl_v[2*i +: 2]};
      any_el = 1'b1;
    end
  end
end

wire [1:0] best_md = md_v[2*best +: 2];
wire       pend_any = trap_p | brk_p | ctx_p;
wire       idle     = state[0];
wire       can_mac  = (stby != `SB_STOP);
wire       take_src = idle && !pend_any && any_el && can_mac &&
                      (best_md == `HM_MAC || cpu_clk_en);
// one-hot clear for the slot being taken
assign clr_v = take_src ? (26'h1 << best) : 26'h0;

// ===================================================
// macro address generation
wire [1:0] md_ms  = ms_mode[1:0];
wire       exch   = ms_mode[2];
wire [1:0] one_k  = {ms_mode[4], ms_mode[3]};
wire       mul_on = ms_mode[5];
wire [1:0] kcnt   = (md_ms == `MS_ONE) ?
                    ((kind == one_k) ? 2'd1 : 2'd0) :
                    xcnt[2*kind +: 2];
wire [7:0]  step  = kind[0] ? 8'h02 : 8'h01;
wire [7:0]  sfr_o = p1 + {4'h0, xi};
wire [15:0] sfr_a = {8'h00, sfr_o};
wire [7:0]  pg_lo = mem_ptr[7:0] + moff;
wire [15:0] mem_a = (md_ms == `MS_ONE) ? {`BUF_PAGE, pg_lo} :
                    (mem_ptr + {8'h00, moff});
wire [15:0] src_a = kind[1] ? mem_a : sfr_a;
wire [15:0] dst_a = kind[1] ? sfr_a : mem_a;
wire [23:0] prod  = bus_rdata * coef;
wire [15:0] pnext = {pbuf[14:0], bus_rdata[7]};

// ===================================================
// trap and break latches, set wins over take
wire take_trap = idle && trap_p;
wire take_brk  = idle && !trap_p && brk_p;
wire take_ctx  = idle && !trap_p && !brk_p && ctx_p;
always @(posedge clk)
begin
  if (!rst_n)
  begin
    trap_p   <= 1'b0;
    brk_p    <= 1'b0;
    ctx_p    <= 1'b0;
    ctx_bank <= 3'h0;
  end
  else
  begin
    trap_p <= operand_err | (trap_p & ~take_trap);
    brk_p  <= software_break_op | (brk_p & ~take_brk);
    ctx_p  <= context_break_op | (ctx_p & ~take_ctx);
    if (context_break_op)
      ctx_bank <= break_bank;
  end
end

// ===================================================
// sequencer: cpu hand-off and macro service
always @(posedge clk)
begin
  if (!rst_n)
  begin
    state       <= S_IDLE;
    sel         <= 5'd0;
    kind        <= 2'd0;
    sub         <= 2'd0;
    xi          <= 4'h0;
    moff        <= 8'h00;
    data_a      <= 16'h0000;
    match       <= 1'b0;
    cnt         <= 8'h00;
    mem_ptr     <= 16'h0000;
    pbuf        <= 16'h0000;
    cpu_int_req <= 1'b0;
    cpu_vector  <= 16'h0000;
    cpu_kind    <= `K_VEC;
    cpu_bank    <= 3'h0;
    cpu_level   <= 2'd0;
    bus_addr    <= 16'h0000;
    bus_sfr     <= 1'b0;
    bus_wdata   <= 16'h0000;
    bus_word    <= 1'b0;
    bus_rd      <= 1'b0;
    bus_wr      <= 1'b0;
  end
  else
  begin
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    case (state)
      S_IDLE:
      begin
        if (take_trap)
        begin
          // no macro or bank switch for the trap
          cpu_int_req <= 1'b1;
          cpu_kind    <= `K_TRAP;
          cpu_vector  <= `VEC_TRAP;
          state       <= S_CPU;
        end
        else if (take_brk)
        begin
          cpu_int_req <= 1'b1;
          cpu_kind    <= `K_BRK;
          cpu_vector  <= `VEC_BRK;
          state       <= S_CPU;
        end
        else if (take_ctx)
        begin
          cpu_int_req <= 1'b1;
          cpu_kind    <= `K_CTX;
          cpu_bank    <= ctx_bank;
          cpu_vector  <= 16'h0000;
          state       <= S_CPU;
        end
        else if (take_src)
        begin
          sel   <= best;
          match <= 1'b0;
          if (best_md == `HM_MAC)
          begin
            // data moves, cpu state left alone
            kind <= 2'd0;
            sub  <= 2'd0;
            xi   <= 4'h0;
            moff <= 8'h00;
            case (md_ms)
              `MS_CNT: state <= S_FIN;
              `MS_PAT:
              begin
                bus_rd   <= 1'b1;
                bus_sfr  <= 1'b1;
                bus_word <= 1'b0;
                bus_addr <= {8'h00, p1};
                state    <= S_PAT;
              end
              default: state <= S_NXT;
            endcase
          end
          else
          begin
            cpu_int_req <= 1'b1;
            cpu_level   <= lvl_v[2*best +: 2];
            cpu_vector  <= vec_of(best);
            if (best_md == `HM_CTX)
            begin
              cpu_kind <= `K_CTX;
              cpu_bank <= bank_v[3*best +: 3];
            end
            else
              cpu_kind <= `K_VEC;
            state <= S_CPU;
          end
        end
      end
      S_CPU:
      begin
        // hold until the cpu takes it
        if (cpu_int_ack)
        begin
          cpu_int_req <= 1'b0;
          state       <= S_IDLE;
        end
      end
      S_NXT:
      begin
        if (sub < kcnt)
        begin
          bus_rd   <= 1'b1;
          bus_addr <= src_a;
          bus_sfr  <= ~kind[1];
          bus_word <= kind[0];
          state    <= S_RD1;
        end
        else if (kind == 2'd3)
          state <= S_FIN;
        else
        begin
          kind <= kind + 2'd1;
          sub  <= 2'd0;
        end
      end
      S_RD1: state <= S_RD2;
      S_RD2:
      begin
        data_a <= bus_rdata;
        if (exch)
        begin
          bus_rd   <= 1'b1;
          bus_addr <= dst_a;
          bus_sfr  <= kind[1];
        end
        state <= S_WR1;
      end
      S_WR1:
      begin
        bus_wr    <= 1'b1;
        bus_addr  <= dst_a;
        bus_sfr   <= kind[1];
        bus_wdata <= data_a;
        state     <= S_WR2;
      end
      S_WR2:
      begin
        // old destination value arrives now
        if (exch)
        begin
          bus_wr    <= 1'b1;
          bus_addr  <= src_a;
          bus_sfr   <= ~kind[1];
          bus_wdata <= bus_rdata;
        end
        sub   <= sub + 2'd1;
        xi    <= xi + 4'h1;
        moff  <= moff + step;
        state <= S_NXT;
      end
      S_PAT: state <= S_PCMP;
      S_PCMP:
      begin
        pbuf  <= pnext;
        match <= (pnext == cmp);
        if (mul_on)
        begin
          bus_rd   <= 1'b1;
          bus_word <= 1'b1;
          bus_addr <= {8'h00, p2};
          state    <= S_PMUL;
        end
        else
          state <= S_FIN;
      end
      S_PMUL: state <= S_PWR;
      S_PWR:
      begin
        bus_wr    <= 1'b1;
        bus_addr  <= {8'h00, p3};
        bus_wdata <= prod[`COEF_FRAC +: 16];
        state     <= S_FIN;
      end
      S_FIN:
      begin
        if (cnt != 8'h00)
          cnt <= cnt - 8'h01;
        if (md_ms == `MS_ONE)
          mem_ptr[7:0] <= pg_lo;
        // a spent counter or a match falls back to a vector
        if (cnt <= 8'h01 || match)
        begin
          cpu_int_req <= 1'b1;
          cpu_kind    <= `K_VEC;
          cpu_vector  <= vec_of(sel);
          cpu_level   <= lvl_v[2*sel +: 2];
          state       <= S_CPU;
        end
        else
          state <= S_IDLE;
      end
      default: state <= S_IDLE;
    endcase
    // software writes override the engine's own update
    if (wr && addr == `A_CNT)
      cnt <= wdata[7:0];
    if (wr && addr == `A_MPTR)
      mem_ptr <= wdata;
    if (wr && addr == `A_PBUF)
      pbuf <= wdata;
  end
end

// ===================================================
// plain configuration registers
always @(posedge clk)
begin
  if (!rst_n)
  begin
    ms_mode <= 6'h00;
    p1      <= 8'h00;
    p2      <= 8'h00;
    p3      <= 8'h00;
    coef    <= 8'h00;
    cmp     <= 16'h0000;
    xcnt    <= 8'h00;
  end
  else if (wr)
  begin
    case (addr)
      `A_MODE: ms_mode <= wdata[5:0];
      `A_P1:   p1      <= wdata[7:0];
      `A_P2:   p2      <= wdata[7:0];
      `A_P3:   p3      <= wdata[7:0];
      `A_COEF: coef    <= wdata[7:0];
      `A_CMP:  cmp     <= wdata;
      `A_XCNT: xcnt    <= wdata[7:0];
      default: ;
    endcase
  end
end

// ===================================================
// standby control and clock enables
// a macro request does not wake halt: it runs beside it
wire wake_h = (any_el && best_md != `HM_MAC) ||
              state[1];
always @(posedge clk)
begin
  if (!rst_n)
  begin
    stby          <= `SB_RUN;
    cpu_clk_en    <= 1'b1;
    main_osc_en   <= 1'b1;
    sub_clk_sel   <= 1'b0;
    periph_clk_en <= 1'b1;
  end
  else
  begin
    if (wr && addr == `STANDBY_CONTROL_REG)
      stby <= wdata[2:0];
    else if (stby == `SB_STOP && any_el)
      stby <= `SB_RUN;
    else if (stby == `SB_HALT && wake_h)
      stby <= `SB_RUN;
    else if (stby == `SB_LPH && wake_h)
      stby <= `SB_LP;
    cpu_clk_en    <= (stby == `SB_RUN) ||
                     (stby == `SB_LP);
    main_osc_en   <= (stby == `SB_RUN) ||
                     (stby == `SB_HALT);
    sub_clk_sel   <= (stby == `SB_LP) ||
                     (stby == `SB_LPH);
    periph_clk_en <= (stby != `SB_STOP);
  end
end

// ===================================================
// readback, zero outside the read cycle
always @(posedge clk)
begin
  if (!rst_n)
    rdata <= 16'h0000;
  else if (!rd)
    rdata <= 16'h0000;
  else if (addr < 8'd26)
    rdata <= {7'h00, rd_v[9*addr[4:0] +: 9]};
  else
  begin
    case (addr)
      `A_MODE: rdata <= {10'h000, ms_mode};
      `A_CNT:  rdata <= {8'h00, cnt};
      `A_P1:   rdata <= {8'h00, p1};
      `A_MPTR: rdata <= mem_ptr;
      `A_P2:   rdata <= {8'h00, p2};
      `A_P3:   rdata <= {8'h00, p3};
      `A_COEF: rdata <= {8'h00, coef};
      `A_CMP:  rdata <= cmp;
      `A_PBUF: rdata <= pbuf;
      `A_XCNT: rdata <= {8'h00, xcnt};
      `STANDBY_CONTROL_REG: rdata <= {13'h0000, stby};
      `A_STAT: rdata <= {9'h000, match, ~idle, sel};
      `A_MSW:  rdata <= msw_of(sel);
      default: rdata <= 16'h0000;
    endcase
  end
end

endmodule

/* File: tb/intc_unit_asserts.sv */
`timescale 1ns/1ps
`include "intc_map.vh"
// ==============================================
// port checker
module intc_unit_asserts
(
  input wire        clk,          // clock
  input wire        rst_n,        // sync reset
  input wire [7:0]  addr,         // reg index
  input wire [15:0] wdata,        // write data
  input wire        wr,           // write strobe
  input wire        rd,           // read strobe
  input wire [15:0] rdata,        // read data
  input wire        operand_err,  // trap pulse
  input wire        cpu_int_ack,  // cpu accept
  input wire        cpu_int_req,  // request out
  input wire [15:0] cpu_vector,   // vector out
  input wire [1:0]  cpu_kind,     // kind out
  input wire [15:0] bus_addr,     // macro addr
  input wire        bus_sfr,      // sfr space
  input wire        bus_wr,       // macro write
  input wire        cpu_clk_en,   // cpu clock
  input wire        main_osc_en,  // oscillator
  input wire        sub_clk_sel,  // subclock
  input wire        periph_clk_en // periph clock
);
  reg  [1:0] mode_q; // written mode
  wire       sb_wr = wr && addr == `STANDBY_CONTROL_REG; // standby write
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==============================================
  // mode mirror for the page check
  always @(posedge clk)
  begin
    if (!rst_n)
      mode_q <= 2'h0;
    else if (wr && addr == `A_MODE)
      mode_q <= wdata[1:0];
  end
  // ==============================================
  // assertions
  a_trap_vector: assert property (
    cpu_int_req && cpu_kind == `K_TRAP |-> cpu_vector == `VEC_TRAP)
    else $error("trap vector wrong");
  a_break_vector: assert property (
    cpu_int_req && cpu_kind == `K_BRK |-> cpu_vector == `VEC_BRK)
    else $error("break vector wrong");
  a_trap_soon: assert property (
    operand_err && !cpu_int_req && cpu_clk_en
    |-> ##[1:12] (cpu_int_req && cpu_kind == `K_TRAP))
    else $error("trap not raised");
  a_req_holds: assert property (
    cpu_int_req && !cpu_int_ack |=> cpu_int_req
    && $stable(cpu_vector) && $stable(cpu_kind))
    else $error("request dropped or changed");
  a_req_drop: assert property (
    cpu_int_req && cpu_int_ack |=> !cpu_int_req)
    else $error("request kept after ack");
  a_vec_range: assert property (
    cpu_int_req && cpu_kind == `K_VEC |-> cpu_vector >= `VEC_BASE
    && cpu_vector <= `VEC_LAST && !cpu_vector[0])
    else $error("vector outside table");
  a_single_page: assert property (
    bus_wr && !bus_sfr && mode_q == `MS_ONE
    |-> bus_addr[15:8] == `BUF_PAGE)
    else $error("single buffer off page");
  a_halt_clocks: assert property (
    sb_wr && wdata[2:0] == `SB_HALT
    |-> ##[1:2] (!cpu_clk_en && periph_clk_en && main_osc_en))
    else $error("halt clocks wrong");
  a_stop_clocks: assert property (
    sb_wr && wdata[2:0] == `SB_STOP
    |-> ##[1:2] !(cpu_clk_en || main_osc_en || periph_clk_en))
    else $error("stop clocks wrong");
  a_lp_clocks: assert property (
    sb_wr && wdata[2:0] == `SB_LP
    |-> ##[1:2] (sub_clk_sel && !main_osc_en && cpu_clk_en))
    else $error("low power clocks wrong");
  a_rdata_idle: assert property (
    !rd |=> rdata == 16'h0)
    else $error("read data outside slot");
  // main scenarios reached
  c_ctx: cover property (cpu_int_req && cpu_kind == `K_CTX);
  c_mem_wr: cover property (bus_wr && !bus_sfr);
  c_trap: cover property (cpu_int_req && cpu_kind == `K_TRAP);
endmodule

bind intc_unit intc_unit_asserts chk (.*);

/* File: tb/macro_bus_model.sv */
`timescale 1ns/1ps
// ==============================================
// memory and sfr space seen by the macro controller
module macro_bus_model
(
  input  wire        clk,       // clock
  input  wire [15:0] bus_addr,  // address
  input  wire        bus_sfr,   // 1: sfr space
  input  wire [15:0] bus_wdata, // write data
  input  wire        bus_rd,    // read strobe
  input  wire        bus_wr,    // write strobe
  output reg  [15:0] bus_rdata  // read data
);
  reg [15:0] sfr_m [0:255]; // sfr space
  reg [15:0] mem_m [0:255]; // memory
  reg [15:0] last = 16'h0;  // last value driven
  // data the cycle after the strobe, inverted otherwise
  always @(posedge clk)
  begin
    if (bus_rd)
      last = bus_sfr ? sfr_m[bus_addr[7:0]] : mem_m[bus_addr[7:0]];
    else
      last = ~last;
    bus_rdata <= last;
    if (bus_wr && bus_sfr)
      sfr_m[bus_addr[7:0]] <= bus_wdata;
    else if (bus_wr)
      mem_m[bus_addr[7:0]] <= bus_wdata;
  end
endmodule

/* File: tb/intc_unit_test.sv */
`timescale 1ns/1ps
`include "intc_map.vh"
module intc_unit_test;
  reg         clk, rst_n, wr, rd, cpu_int_ack;
  reg  [7:0]  addr;
  reg  [15:0] wdata;
  reg  [25:0] src_req;
  reg  [4:0]  ev;          // pin2, timer4, trap, break, ctx break
  reg  [2:0]  break_bank;
  wire [15:0] rdata, cpu_vector, bus_addr, bus_wdata, bus_rdata;
  wire        cpu_int_req, bus_sfr, bus_rd, bus_wr;
  wire [1:0]  cpu_kind, cpu_level;
  wire [2:0]  cpu_bank;
  wire        cpu_clk_en, main_osc_en, sub_clk_sel, periph_clk_en;
  wire [3:0]  clks = {cpu_clk_en, main_osc_en, sub_clk_sel, periph_clk_en};
  reg  [4:0]  slot [0:3];  // slots
  reg  [15:0] vec [0:3];   // vectors
  reg  [7:0]  sbt [1:4];   // standby: {mask, clock pattern}
  integer     fails, comparisons, i;

  intc_unit dut
  (
    .*, .pin2_edge_req(ev[4]), .timer4_match_req(ev[3]),
    .operand_err(ev[2]), .software_break_op(ev[1]),
    .context_break_op(ev[0]), .bus_word()
  );
  macro_bus_model mdl (.*);

  always #2 clk = ~clk;

  // ==============================================
  // helpers
  task summarize;
  begin
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // one-cycle write strobe
  task wreg(input [7:0] a, input [15:0] d);
  begin
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  // data stand one cycle after rd
  task rreg(input [7:0] a, input [15:0] exp);
  begin
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  end
  endtask
  // one-cycle request pulses
  task fire(input [25:0] s, input [4:0] e);
  begin
    @(posedge clk);
    src_req <= s;
    ev      <= e;
    @(posedge clk);
    src_req <= 26'h0;
    ev      <= 5'h0;
  end
  endtask
  // wait, check, acknowledge
  task take(input [1:0] k, input [15:0] v, input [2:0] b);
    integer n;
  begin
    n = 0;
    while (cpu_int_req !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    if (n == 40)
    begin
      fails = fails + 1;
      summarize;
    end
    chk({14'h0, cpu_kind}, {14'h0, k});
    if (k == `K_CTX)
      chk({13'h0, cpu_bank}, {13'h0, b});
    else
      chk(cpu_vector, v);
    @(posedge clk);
    cpu_int_ack <= 1'b1;
    @(posedge clk);
    cpu_int_ack <= 1'b0;
    @(posedge clk);
    #1;
  end
  endtask
  task tv(input [15:0] v);
    take(`K_VEC, v, 3'h0);
  endtask

  // ==============================================
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    summarize;
  end

  // ==============================================
  // main sequence
  initial
  begin
    clk = 0; rst_n = 0; wr = 0; rd = 0; cpu_int_ack = 0;
    addr = 0; wdata = 0; src_req = 0; ev = 0; break_bank = 3'h5;
    fails = 0; comparisons = 0;
    slot[0] = 5'd4; slot[1] = 5'd20; slot[2] = 5'd21; slot[3] = 5'd25;
    vec[0] = 16'h000e; vec[1] = 16'h002e;
    vec[2] = 16'h0030; vec[3] = 16'h003a;
    sbt[1] = 8'hf5; sbt[2] = 8'hf0; sbt[3] = 8'hea; sbt[4] = 8'he2;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({12'h0, clks}, 16'h000d);
    rreg(8'h15, 16'h0007);
    rreg(8'h30, 16'h0000);
    // masked slot waits, then fires once unmasked
    fire(26'h1 << 21, 5'h0);
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0, cpu_int_req}, 16'h0);
    wreg(8'h15, 16'h0008);
    tv(16'h0030);
    for (i = 0; i < 4; i = i + 1)
    begin
      wreg({3'h0, slot[i]}, 16'h0000);
      fire(26'h1 << slot[i], 5'h0);
      tv(vec[i]);
    end
    // shared slot from both sources
    wreg(8'h0f, 16'h0000);
    fire(26'h0, 5'h10);
    tv(16'h0024);
    fire(26'h0, 5'h08);
    tv(16'h0024);
    // ties to the lower slot; a better level first
    fire((26'h1 << 4) | (26'h1 << 21), 5'h0);
    tv(16'h000e);
    tv(16'h0030);
    wreg(8'h04, 16'h0002);
    fire((26'h1 << 4) | (26'h1 << 25), 5'h0);
    tv(16'h003a);
    tv(16'h000e);
    chk({14'h0, cpu_level}, 16'h0002);
    // trap beats a slot, then the breaks
    fire(26'h1 << 21, 5'h04);
    take(`K_TRAP, 16'h003c, 3'h0);
    tv(16'h0030);
    fire(26'h0, 5'h02);
    take(`K_BRK, 16'h003e, 3'h0);
    fire(26'h0, 5'h01);
    take(`K_CTX, 16'h0000, 3'h5);
    // slot 20 switches context into bank 3
    wreg(8'h14, 16'h00d0);
    fire(26'h1 << 20, 5'h0);
    take(`K_CTX, 16'h0000, 3'h3);
    // single byte transfers, sfr to buffer
    wreg(8'h14, 16'h0020);
    wreg(`A_MODE, 16'h0002);
    wreg(`A_CNT, 16'h0002);
    wreg(`A_P1, 16'h0010);
    wreg(`A_MPTR, 16'h0005);
    mdl.sfr_m[16] = 16'h00c3;
    fire(26'h1 << 20, 5'h0);
    repeat (12) @(posedge clk);
    #1;
    chk(mdl.mem_m[5] & 16'h00ff, 16'h00c3);
    chk({15'h0, cpu_int_req}, 16'h0);
    rreg(`A_CNT, 16'h0001);
    mdl.sfr_m[16] = 16'h007e;
    fire(26'h1 << 20, 5'h0);
    tv(16'h002e);
    chk(mdl.mem_m[6] & 16'h00ff, 16'h007e);
    // compound byte exchange, count runs out
    wreg(`A_MODE, 16'h0005);
    wreg(`A_XCNT, 16'h0001);
    wreg(`A_CNT, 16'h0001);
    wreg(`A_P1, 16'h0020);
    wreg(`A_MPTR, 16'h0040);
    mdl.sfr_m[32] = 16'h0011;
    mdl.mem_m[64] = 16'h0022;
    fire(26'h1 << 20, 5'h0);
    tv(16'h002e);
    chk(mdl.sfr_m[32] & 16'h00ff, 16'h0022);
    chk(mdl.mem_m[64] & 16'h00ff, 16'h0011);
    // pattern mode: shifted bit 7 matches compare
    wreg(`A_MODE, 16'h0003);
    wreg(`A_CMP, 16'h0001);
    wreg(`A_PBUF, 16'h0000);
    wreg(`A_CNT, 16'h0005);
    wreg(`A_P1, 16'h0030);
    mdl.sfr_m[48] = 16'h0080;
    fire(26'h1 << 20, 5'h0);
    tv(16'h002e);
    rreg(`A_PBUF, 16'h0001);
    rreg(`A_MSW, 16'hfe2e);
    // standby modes and back to run
    for (i = 1; i < 5; i = i + 1)
    begin
      wreg(`STANDBY_CONTROL_REG, i[15:0]);
      repeat (3) @(posedge clk);
      #1;
      chk({12'h0, clks & sbt[i][7:4]}, {12'h0, sbt[i][3:0]});
    end
    wreg(`STANDBY_CONTROL_REG, 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    chk({12'h0, clks}, 16'h000d);
    summarize;
  end
endmodule
